// *** hdl/status_flag_aggregator.sv ***
// Status register bank with readback routing and channel range flags
`timescale 1ns/1ps
module status_flag_aggregator
	import status_flag_pkg::*;
#(
	parameter int NCH = NUM_CHANNELS
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// Register access from the serial front end
	input  wire reg_wr_t    reg_wr,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data_ff,
	// Converter core events
	input  wire core_evt_t  core_evt,
	// Readback serial data and its routing
	input  wire logic       readback_bit,
	output logic            config_serial_out_pin_ff,
	output logic            conversion_output_lane_zero_ff,
	input  wire logic       conv_lane_zero_data,
	// Status summaries
	output logic            device_ok_ff,
	output logic            range_violation_summary_ff
);

	// Busy pin is asynchronous to the register logic
	typedef struct packed {
		logic [2:0] busy_sync;
		logic       busy_seen;
		logic       init_done;
		logic       readback_on_lane_zero;
		logic       device_ok;
		logic       reset_seen;
		logic       trim_err;
		logic       map_err;
		logic [7:0] serial_err;
		logic [7:0] rd_data;
		logic       cfg_out;
		logic       lane0_out;
		logic       range_sum;
	} state_t;

	// Registered and next state
	state_t st_ff;
	state_t nxt_st;

	// Channel flag bytes from the sticky banks
	logic [7:0] over_flags;
	logic [7:0] under_flags;
	// Clear strobes toward the banks
	logic [7:0] over_clr;
	logic [7:0] under_clr;

	// Decode a write to a given register
	function automatic logic wr_hit(input reg_wr_t w, input logic [7:0] a);
		return w.wr_en && (w.addr == a);
	endfunction : wr_hit

	// Assemble the health byte from live state
	function automatic logic [7:0] health_byte(input state_t s, input logic [7:0] ov,
		input logic [7:0] un, input core_evt_t e);
		logic [7:0] b;
		b = ZERO_BYTE;
		b[BIT_DEVICE_OK]  = s.device_ok;
		b[BIT_RESET_SEEN] = s.reset_seen;
		b[BIT_TRIM_ERR]   = s.trim_err;
		b[BIT_MAP_ERR]    = s.map_err;
		// RULE_08 serial error summary
		b[BIT_SERIAL_SUM] = |s.serial_err;
		// RULE_09 range summary
		b[BIT_RANGE_SUM]  = |{ov, un};
		// RULE_10 power down level
		b[BIT_POWER_DOWN] = e.power_down;
		// RULE_11 sleep summary
		b[BIT_SLEEP_SUM]  = |e.sleep_bits;
		return b;
	endfunction : health_byte

	// RULE_13 underrange sticky flags
	w1c_flag_bank #(.WIDTH(NCH)) u_under (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.set_bits (core_evt.under_hit),
		.clr_bits (under_clr),
		.flags_ff (under_flags)
	);

	// RULE_12 overrange sticky flags
	w1c_flag_bank #(.WIDTH(NCH)) u_over (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.set_bits (core_evt.over_hit),
		.clr_bits (over_clr),
		.flags_ff (over_flags)
	);

	// Clear strobes: only a write of one clears a flag
	always_comb begin
		over_clr  = wr_hit(reg_wr, ADDR_OVER)  ? reg_wr.wdata : ZERO_BYTE;
		under_clr = wr_hit(reg_wr, ADDR_UNDER) ? reg_wr.wdata : ZERO_BYTE;
	end

	// Next state of all control and status bits
	always_comb begin
		logic hw_wr;
		logic [7:0] wd;
		hw_wr  = wr_hit(reg_wr, ADDR_HEALTH);
		wd     = reg_wr.wdata;
		nxt_st = st_ff;
		// Three-stage busy synchroniser
		nxt_st.busy_sync = {st_ff.busy_sync[1:0], core_evt.busy};
		if (st_ff.busy_sync[1] == st_ff.busy_sync[2] && st_ff.busy_sync[2]) begin
			nxt_st.busy_seen = 1'b1;
		end
		// RULE_02 ok at busy fall
		if (!st_ff.init_done && st_ff.busy_seen
			&& st_ff.busy_sync[1] == st_ff.busy_sync[2] && !st_ff.busy_sync[2]) begin
			nxt_st.init_done = 1'b1;
			nxt_st.device_ok = 1'b1;
		end
		// RULE_03 corruption after init latches error
		if (st_ff.init_done && core_evt.state_corrupt) begin
			nxt_st.device_ok = 1'b0;
		end
		// RULE_04 reset flag clears
		if (hw_wr && wd[BIT_RESET_SEEN]) begin
			nxt_st.reset_seen = 1'b0;
		end
		// RULE_05 trim error sticky
		nxt_st.trim_err = (st_ff.trim_err & ~(hw_wr & wd[BIT_TRIM_ERR])) | core_evt.trim_err;
		// RULE_06 map error sticky
		nxt_st.map_err = (st_ff.map_err & ~(hw_wr & wd[BIT_MAP_ERR])) | core_evt.map_err;
		// RULE_14 serial error flags
		nxt_st.serial_err = (st_ff.serial_err | core_evt.serial_err) & SERIAL_ERR_MASK;
		// RULE_16 only the select bit is writable
		if (wr_hit(reg_wr, ADDR_READBACK_SEL)) begin
			nxt_st.readback_on_lane_zero = wd[BIT_LANE_ZERO];
		end
		// RULE_01 route readback data
		nxt_st.cfg_out   = st_ff.readback_on_lane_zero ? 1'b0 : readback_bit;
		nxt_st.lane0_out = st_ff.readback_on_lane_zero ? readback_bit : conv_lane_zero_data;
		nxt_st.range_sum = |{over_flags, under_flags};
		// Read mux; unmapped addresses read zero
		unique case (rd_addr)
			ADDR_READBACK_SEL: begin
				nxt_st.rd_data = {7'h00, st_ff.readback_on_lane_zero};
			end
			ADDR_HEALTH: begin
				nxt_st.rd_data = health_byte(st_ff, over_flags, under_flags, core_evt);
			end
			ADDR_OVER: begin
				nxt_st.rd_data = over_flags;
			end
			ADDR_UNDER: begin
				nxt_st.rd_data = under_flags;
			end
			default: begin
				nxt_st.rd_data = ZERO_BYTE;
			end
		endcase
	end

	// State register; reset marks that a reset happened
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff            <= '0;
			st_ff.reset_seen <= RST_HEALTH[BIT_RESET_SEEN];
			st_ff.readback_on_lane_zero <= RST_READBACK_SEL[BIT_LANE_ZERO];
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data_ff                     = st_ff.rd_data;
	assign config_serial_out_pin_ff       = st_ff.cfg_out;
	assign conversion_output_lane_zero_ff = st_ff.lane0_out;
	assign device_ok_ff                   = st_ff.device_ok;
	assign range_violation_summary_ff     = st_ff.range_sum;

	// RULE_01 idle pin when lane zero
	a_lane_route: assert property (@(posedge sys_clk) disable iff (!rstn)
		st_ff.readback_on_lane_zero |=> !config_serial_out_pin_ff)
		else $error("config pin active while routed to lane zero"); // RULE_01
	// RULE_02 ok only after init
	a_ok_after_init: assert property (@(posedge sys_clk) disable iff (!rstn)
		device_ok_ff |-> st_ff.init_done)
		else $error("device ok before init"); // RULE_02
	// RULE_03 error persists
	a_ok_stays_low: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(device_ok_ff) |=> !device_ok_ff [*4])
		else $error("device ok recovered without reset"); // RULE_03
	// RULE_04 reset flag only clears by write
	a_reset_flag_w1c: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(st_ff.reset_seen) |-> $past(wr_hit(reg_wr, ADDR_HEALTH) && reg_wr.wdata[BIT_RESET_SEEN]))
		else $error("reset flag cleared without write"); // RULE_04
	// RULE_05 trim error sets
	a_trim_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
		core_evt.trim_err |=> st_ff.trim_err)
		else $error("trim error not captured"); // RULE_05
	// RULE_06 map error sets
	a_map_sets: assert property (@(posedge sys_clk) disable iff (!rstn)
		core_evt.map_err |=> st_ff.map_err)
		else $error("map error not captured"); // RULE_06
	// RULE_09 range summary follows flags
	a_range_sum: assert property (@(posedge sys_clk) disable iff (!rstn)
		(|{over_flags, under_flags}) |=> range_violation_summary_ff)
		else $error("range summary missed"); // RULE_09
	// RULE_16 reserved bits read zero
	a_sel_reserved: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rd_addr == ADDR_READBACK_SEL) |=> (rd_data_ff[7:1] == 7'h00))
		else $error("reserved select bits nonzero"); // RULE_16
	// RULE_14 unimplemented serial bits stay clear
	a_serial_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
		(st_ff.serial_err & ~SERIAL_ERR_MASK) == ZERO_BYTE)
		else $error("unimplemented serial error bit set"); // RULE_14

	// Main scenarios
	c_init_done: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(device_ok_ff));
	c_corrupt:   cover property (@(posedge sys_clk) disable iff (!rstn) $fell(device_ok_ff));
	c_lane_zero: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(st_ff.readback_on_lane_zero));
	c_over_clr:  cover property (@(posedge sys_clk) disable iff (!rstn) $fell(|over_flags));

endmodule : status_flag_aggregator

// *** hdl/status_flag_pkg.sv ***
// Constants, register map and carrier types of the status flag aggregator
// Summary of operation
// RULE_01 - Select bit routes readback to lane zero
// RULE_02 - Device-ok sets when busy falls after init
// RULE_03 - Corruption clears device-ok until global reset; corruption before init is ignored
// RULE_04 - Reset flag set by reset, write-one clears
// RULE_05 - Trim check error sticky, write-one clears
// RULE_06 - Register-map check error sticky, write-one clears
// RULE_07 - Host ignores map error unless checksum programmed
// RULE_08 - Bit 3 ORs the serial error register
// RULE_09 - Bit 2 ORs over and under flags
// RULE_10 - Bit 1 high while powered down
// RULE_11 - Bit 0 ORs the channel sleep register
// RULE_12 - Channel over limit sets its sticky bit
// RULE_13 - Channel under limit sets its sticky bit
// RULE_14 - Serial error register holds five sticky flags
// RULE_15 - Set beats clear; writing zero keeps flags
// RULE_16 - Read-only and reserved bits ignore writes, read zero
package status_flag_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_READBACK_SEL = 8'h14;
	localparam logic [7:0] ADDR_HEALTH       = 8'h20;
	localparam logic [7:0] ADDR_OVER         = 8'h21;
	localparam logic [7:0] ADDR_UNDER        = 8'h22;

	// Reset values
	localparam logic [7:0] RST_READBACK_SEL = 8'h00;
	localparam logic [7:0] RST_HEALTH       = 8'h40;
	localparam logic [7:0] RST_CHAN_FLAGS   = 8'h00;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;

	// Field positions
	localparam int BIT_LANE_ZERO   = 0;
	localparam int BIT_DEVICE_OK   = 7;
	localparam int BIT_RESET_SEEN  = 6;
	localparam int BIT_TRIM_ERR    = 5;
	localparam int BIT_MAP_ERR     = 4;
	localparam int BIT_SERIAL_SUM  = 3;
	localparam int BIT_RANGE_SUM   = 2;
	localparam int BIT_POWER_DOWN  = 1;
	localparam int BIT_SLEEP_SUM   = 0;

	// Serial error register: only these bits are implemented
	localparam logic [7:0] SERIAL_ERR_MASK = 8'h9D;

	// Number of monitored channels
	localparam int NUM_CHANNELS = 8;

	// Register write request
	typedef struct packed {
		logic       wr_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_wr_t;

	// Event inputs from the converter core
	typedef struct packed {
		logic       busy;
		logic       state_corrupt;
		logic       trim_err;
		logic       map_err;
		logic       power_down;
		logic [7:0] serial_err;
		logic [7:0] sleep_bits;
		logic [7:0] over_hit;
		logic [7:0] under_hit;
	} core_evt_t;

endpackage : status_flag_pkg

// *** hdl/w1c_flag_bank.sv ***
// Sticky write-one-to-clear flag byte with set priority
`timescale 1ns/1ps
module w1c_flag_bank
	import status_flag_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// Set events and clear strobes
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic [WIDTH-1:0] clr_bits,
	// Registered flags
	output logic      [WIDTH-1:0] flags_ff
);

	// Next flag value
	logic [WIDTH-1:0] nxt_flags;

	// RULE_15 set wins clear
	always_comb begin
		nxt_flags = (flags_ff & ~clr_bits) | set_bits;
	end

	// Flag register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// RULE_15 set has priority
	a_set_beats_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
		(set_bits != '0) |=> ((flags_ff & $past(set_bits)) == $past(set_bits)))
		else $error("set event lost"); // RULE_15

	// RULE_15 zero write keeps
	a_hold_no_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
		(clr_bits == '0) |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
		else $error("flag dropped without clear"); // RULE_15

endmodule : w1c_flag_bank

// *** tb/host_link_model.sv ***
// Host controller model that launches register writes toward the device
`timescale 1ns/1ps
module host_link_model
	import status_flag_pkg::*;
(
	// Clock
	input  wire logic    sys_clk,
	// Request queued by the bench
	input  wire reg_wr_t req,
	// Write port toward the device
	output reg_wr_t      reg_wr
);
	// Requests change only after a falling edge and hold for a full cycle
	// map error left to host policy
	always @(negedge sys_clk) begin
		reg_wr <= req;
	end
endmodule : host_link_model

// *** tb/status_flag_aggregator_bench.sv ***
// Self-checking bench of the status flag aggregator
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module status_flag_aggregator_bench;
	import status_flag_pkg::*;
	// Stimulus and observed signals
	logic       sys_clk = 0;
	logic       rstn = 0;
	reg_wr_t    req = '0;
	reg_wr_t    reg_wr;
	logic [7:0] rd_addr = 8'h00;
	logic [7:0] rd_data_ff;
	core_evt_t  ev = '0;
	logic       readback_bit = 0;
	logic       conv_lane_zero_data = 0;
	logic       cfg_pin, lane_pin, ok_pin, range_pin;
	// Counters and reference model state
	int         errors = 0, compares = 0, r, i;
	int         m_ok, m_rst = 1, m_trim, m_map, m_ser, m_over, m_under;

	// Free running 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	// Host side partner
	host_link_model host (.sys_clk(sys_clk), .req(req), .reg_wr(reg_wr));

	// Device under test
	status_flag_aggregator dut (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .rd_addr(rd_addr),
		.rd_data_ff(rd_data_ff), .core_evt(ev), .readback_bit(readback_bit),
		.config_serial_out_pin_ff(cfg_pin), .conversion_output_lane_zero_ff(lane_pin),
		.conv_lane_zero_data(conv_lane_zero_data), .device_ok_ff(ok_pin), .range_violation_summary_ff(range_pin));

	// Expected health byte built from the model
	function automatic logic [7:0] exp_health();
		return 8'(m_ok * 128 + m_rst * 64 + m_trim * 32 + m_map * 16 + m_ser * 8
			+ ((m_over | m_under) != 0) * 4 + ev.power_down * 2 + (ev.sleep_bits != 0));
	endfunction : exp_health

	// Wait a number of falling edges
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick

	// One register write through the host model
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{1'b1, a, d};
		tick(1);
		req <= '0;
		tick(3);
	endtask : wr

	// One register read compared with the model
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_addr <= a;
		tick(2);
		`CHK(rd_data_ff, e)
	endtask : rd

	// Verdict and end of run
	task automatic print_verdict();
		if (errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		void'($urandom(80));
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn <= 1'b1;
		tick(1);
		// Reset values and an unmapped place
		rd(ADDR_READBACK_SEL, 8'h00);
		rd(ADDR_HEALTH, 8'h40);
		rd(ADDR_OVER, 8'h00);
		rd(ADDR_UNDER, 8'h00);
		rd(8'h30, 8'h00);
		// Power-on init completes at the end of busy
		ev.busy <= 1'b1;
		tick(5);
		`CHK(ok_pin, 1'b0)
		ev.busy <= 1'b0;
		for (i = 0; i < 20 && ok_pin !== 1'b1; i++) tick(1);
		if (i == 20) begin
			errors++;
			$display("MISMATCH %0t device ok never set", $time);
			print_verdict();
		end
		m_ok = 1;
		rd(ADDR_HEALTH, exp_health());
		// Trim and map check errors, then write-one clears
		ev.trim_err <= 1'b1;
		ev.map_err <= 1'b1;
		tick(1);
		ev.trim_err <= 1'b0;
		ev.map_err <= 1'b0;
		m_trim = 1;
		m_map = 1;
		tick(2);
		rd(ADDR_HEALTH, exp_health());
		wr(ADDR_HEALTH, 8'h00);
		rd(ADDR_HEALTH, exp_health());
		wr(ADDR_HEALTH, 8'h20);
		m_trim = 0;
		rd(ADDR_HEALTH, exp_health());
		wr(ADDR_HEALTH, 8'hDF);
		m_rst = 0;
		m_map = 0;
		rd(ADDR_HEALTH, exp_health());
		// Random channel range events and partial clears
		for (i = 0; i < 8; i++) begin
			r = $urandom;
			ev.over_hit <= r[7:0];
			ev.under_hit <= r[15:8];
			tick(1);
			ev.over_hit <= 8'h00;
			ev.under_hit <= 8'h00;
			m_over |= r[7:0];
			m_under |= r[15:8];
			tick(2);
			`CHK(range_pin, 1'((m_over | m_under) != 0))
			rd(ADDR_OVER, 8'(m_over));
			rd(ADDR_UNDER, 8'(m_under));
			rd(ADDR_HEALTH, exp_health());
			wr(ADDR_OVER, r[23:16]);
			m_over &= ~r[23:16];
			wr(ADDR_UNDER, r[31:24]);
			m_under &= ~r[31:24];
		end
		// A set event during a clear write wins
		ev.over_hit <= 8'h08;
		wr(ADDR_OVER, 8'hFF);
		ev.over_hit <= 8'h00;
		m_over = 8;
		m_under = 0;
		wr(ADDR_UNDER, 8'hFF);
		rd(ADDR_OVER, 8'h08);
		// Serial errors: unimplemented bits ignored, implemented bit sticks
		ev.serial_err <= 8'h62;
		tick(1);
		ev.serial_err <= 8'h00;
		tick(2);
		rd(ADDR_HEALTH, exp_health());
		ev.serial_err <= 8'h80;
		tick(1);
		ev.serial_err <= 8'h00;
		m_ser = 1;
		tick(2);
		rd(ADDR_HEALTH, exp_health());
		// Sleep and power-down levels
		ev.sleep_bits <= 8'h10;
		ev.power_down <= 1'b1;
		tick(3);
		rd(ADDR_HEALTH, exp_health());
		ev.sleep_bits <= 8'h00;
		ev.power_down <= 1'b0;
		tick(3);
		rd(ADDR_HEALTH, exp_health());
		// Readback routing for both select values
		for (i = 0; i < 8; i++) begin
			r = $urandom;
			if (i % 4 == 0) wr(ADDR_READBACK_SEL, {r[7:1], i[2]});
			rd(ADDR_READBACK_SEL, {7'h00, i[2]});
			readback_bit <= r[8];
			conv_lane_zero_data <= r[9];
			tick(2);
			`CHK(cfg_pin, i[2] ? 1'b0 : r[8])
			`CHK(lane_pin, i[2] ? r[8] : r[9])
		end
		// Corruption drops device ok until global reset
		ev.state_corrupt <= 1'b1;
		tick(1);
		ev.state_corrupt <= 1'b0;
		tick(6);
		m_ok = 0;
		`CHK(ok_pin, 1'b0)
		rd(ADDR_HEALTH, exp_health());
		// Global reset in mid-run: flags restart, reset flag set again
		rstn <= 1'b0;
		tick(2);
		rstn <= 1'b1;
		tick(1);
		m_rst = 1;
		m_ser = 0;
		m_over = 0;
		m_under = 0;
		`CHK(ok_pin, 1'b0)
		rd(ADDR_HEALTH, exp_health());
		rd(ADDR_READBACK_SEL, 8'h00);
		rd(ADDR_OVER, 8'h00);
		// A fresh power-on init after the reset sets device ok again
		ev.busy <= 1'b1;
		tick(5);
		ev.busy <= 1'b0;
		tick(6);
		m_ok = 1;
		`CHK(ok_pin, 1'b1)
		rd(ADDR_HEALTH, exp_health());
		print_verdict();
	end
endmodule : status_flag_aggregator_bench
